//--- hw/hrcs_pkg.sv
// Package with timing constants, modes, states and carriers for the sequencer.
package hrcs_pkg;

	localparam int HRCS_CLK_MHZ = 250;
	localparam int HRCS_PORTS = 4;
	localparam int HRCS_ADDR_W = 7;
	localparam int HRCS_CFG_W = 8;

	// Recovery time in microseconds; longest time, so rounded down.
	localparam int HRCS_RECOVER_US = 500;
	localparam int HRCS_RECOVER_CYC = HRCS_RECOVER_US * HRCS_CLK_MHZ;

	localparam logic [1:0] HRCS_SEL_STRAP = 2'h0;
	localparam logic [1:0] HRCS_SEL_EEPROM = 2'h1;
	localparam logic [1:0] HRCS_SEL_SMBUS = 2'h2;

	localparam logic [HRCS_ADDR_W-1:0] HRCS_ADDR_RST = 7'h00;
	localparam logic [HRCS_CFG_W-1:0] HRCS_CFG_RST = 8'h00;
	localparam logic [HRCS_PORTS-1:0] HRCS_PORT_OFF = 4'h0;

	typedef enum logic [2:0] {
		HRCS_RECOVER,
		HRCS_SELECT,
		HRCS_EEPROM_RD,
		HRCS_SMB_WAIT,
		HRCS_ATTACHED
	} hrcs_state_e;

	// Configuration handed in by the SMBus slave loader; the EEPROM reader has its own ports.
	typedef struct packed {
		logic done;
		logic [HRCS_PORTS-1:0] charge_port_enable;
	} hrcs_load_s;

	// Requests from the USB device core after configuration.
	typedef struct packed {
		logic set_addr;
		logic [HRCS_ADDR_W-1:0] addr;
		logic set_cfg;
		logic [HRCS_CFG_W-1:0] cfg;
		logic [HRCS_PORTS-1:0] port_on;
	} hrcs_core_s;

endpackage

//--- hw/hrcs_sequencer.sv
// Reset and start-up sequencer of the hub controller.
//
// Overview of operation
// - Become operational within 500 us after reset release.
// - Choose strap, EEPROM or SMBus configuration path from select straps.
// - SMBus mode waits without limit for load; no attach before it ends.
// - EEPROM mode reads configuration after recovery, attaches only afterwards.
// - SMBus mode attaches immediately once the external load finishes.
// - Upstream bus reset sets the device address to zero.
// - Upstream bus reset returns the device to unconfigured.
// - Bus reset drops port power except ports with charging enabled.
// - Bus reset empties every transaction translator buffer.
// - Bus reset while suspended wakes the device to active.
// - Bus reset is never forwarded to downstream ports.
`timescale 1ns/1ns

module hrcs_sequencer
	import hrcs_pkg::*;
#(
	parameter int RECOVER_CYC = HRCS_RECOVER_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] cfg_sel,
	input wire logic eeprom_done,
	input wire hrcs_load_s smb_load,
	input wire logic [HRCS_PORTS-1:0] eeprom_charge,
	input wire logic usb_bus_reset,
	input wire logic suspend_req,
	input wire hrcs_core_s core_req,
	output logic operational,
	output logic eeprom_start,
	output logic attach,
	output logic [HRCS_ADDR_W-1:0] usb_addr,
	output logic [HRCS_CFG_W-1:0] usb_config,
	output logic [HRCS_PORTS-1:0] port_power_enable,
	output logic [HRCS_PORTS-1:0] charge_port_enable,
	output logic transaction_translator_flush,
	output logic suspended,
	output logic downstream_reset
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; straps are sampled once recovery ends.

	logic [1:0] sel_s1_r, sel_s2_r;
	logic brst_s1_r, brst_s2_r;
	logic susp_s1_r, susp_s2_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel_s1_r <= HRCS_SEL_STRAP;
			sel_s2_r <= HRCS_SEL_STRAP;
			brst_s1_r <= 1'b0;
			brst_s2_r <= 1'b0;
			susp_s1_r <= 1'b0;
			susp_s2_r <= 1'b0;
		end else begin
			sel_s1_r <= cfg_sel;
			sel_s2_r <= sel_s1_r;
			brst_s1_r <= usb_bus_reset;
			brst_s2_r <= brst_s1_r;
			susp_s1_r <= suspend_req;
			susp_s2_r <= susp_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start-up sequence.

	hrcs_state_e state_r, state_nxt;
	logic [31:0] rec_cnt_r;
	logic rec_done;

	assign rec_done = (rec_cnt_r == 32'(RECOVER_CYC - 1));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rec_cnt_r <= 32'h0;
		end else if (state_r == HRCS_RECOVER && !rec_done) begin
			rec_cnt_r <= rec_cnt_r + 32'h1;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			HRCS_RECOVER: begin
				if (rec_done) begin
					state_nxt = HRCS_SELECT;
				end
			end
			HRCS_SELECT: begin
				case (sel_s2_r)
					HRCS_SEL_EEPROM: state_nxt = HRCS_EEPROM_RD;
					HRCS_SEL_SMBUS: state_nxt = HRCS_SMB_WAIT;
					default: state_nxt = HRCS_ATTACHED;
				endcase
			end
			HRCS_EEPROM_RD: begin
				if (eeprom_done) begin
					state_nxt = HRCS_ATTACHED;
				end
			end
			HRCS_SMB_WAIT: begin
				// No timeout here: the processor may take as long as it likes.
				if (smb_load.done) begin
					state_nxt = HRCS_ATTACHED;
				end
			end
			HRCS_ATTACHED: state_nxt = HRCS_ATTACHED;
			default: state_nxt = HRCS_RECOVER;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= HRCS_RECOVER;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			operational <= 1'b0;
			eeprom_start <= 1'b0;
			attach <= 1'b0;
		end else begin
			operational <= (state_nxt != HRCS_RECOVER);
			eeprom_start <= (state_r == HRCS_SELECT) &&
				(state_nxt == HRCS_EEPROM_RD);
			attach <= (state_nxt == HRCS_ATTACHED);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Loaded configuration.

	// Done and its data are taken in one edge, so the loader needs no hold.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			charge_port_enable <= HRCS_PORT_OFF;
		end else if (state_r == HRCS_EEPROM_RD && eeprom_done) begin
			charge_port_enable <= eeprom_charge;
		end else if (state_r == HRCS_SMB_WAIT && smb_load.done) begin
			charge_port_enable <= smb_load.charge_port_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Upstream bus reset handling; it wins over any core request.

	// Decoded in several places: the host owns the hub only once attached.
	function automatic logic is_live(input hrcs_state_e st);
		return st == HRCS_ATTACHED;
	endfunction

	// A reset seen before attach is ignored; the host cannot see the hub yet.
	logic brst;
	assign brst = brst_s2_r && is_live(state_r);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			usb_addr <= HRCS_ADDR_RST;
			usb_config <= HRCS_CFG_RST;
		end else if (brst) begin
			usb_addr <= HRCS_ADDR_RST;
			usb_config <= HRCS_CFG_RST;
		end else begin
			if (core_req.set_addr) begin
				usb_addr <= core_req.addr;
			end
			if (core_req.set_cfg) begin
				usb_config <= core_req.cfg;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_power_enable <= HRCS_PORT_OFF;
		end else if (!is_live(state_r) || brst) begin
			// Charging ports keep power so an attached phone keeps charging.
			port_power_enable <= charge_port_enable;
		end else begin
			port_power_enable <= core_req.port_on | charge_port_enable;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			transaction_translator_flush <= 1'b0;
		end else begin
			transaction_translator_flush <= brst;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			suspended <= 1'b0;
		end else if (brst) begin
			suspended <= 1'b0;
		end else begin
			suspended <= susp_s2_r && is_live(state_r);
		end
	end

	// Tied low on purpose: downstream devices never see the upstream reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			downstream_reset <= 1'b0;
		end else begin
			downstream_reset <= 1'b0;
		end
	end

endmodule

//--- test/hrcs_partner.sv
// Model of the EEPROM reader and the upstream host.
`timescale 1ns/1ns
module hrcs_partner
	import hrcs_pkg::*;
#(
	parameter int RD = 6,
	parameter int WT = 20,
	parameter int RL = 12
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic eeprom_start,
	input wire logic attach,
	input wire logic [HRCS_PORTS-1:0] charge,
	output logic eeprom_done,
	output logic [HRCS_PORTS-1:0] eeprom_charge,
	output logic usb_bus_reset
);
	int rd;
	int hc;
	// Data outside the done cycle is inverted so a late sample shows up.
	assign eeprom_charge = eeprom_done ? charge : ~charge;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd <= 0;
			eeprom_done <= 1'b0;
			hc <= 0;
			usb_bus_reset <= 1'b0;
		end else begin
			rd <= eeprom_start ? RD : (rd > 0 ? rd - 1 : 0);
			eeprom_done <= (rd == 1);
			hc <= attach ? hc + 1 : 0;
			usb_bus_reset <= hc >= WT && hc < WT + RL;
		end
	end
endmodule

//--- test/hrcs_sequencer_sva.sv
// Port assertions for the reset sequencer.
`timescale 1ns/1ns
module hrcs_sequencer_sva
	import hrcs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic usb_bus_reset,
	input wire logic operational,
	input wire logic eeprom_start,
	input wire logic attach,
	input wire logic [HRCS_ADDR_W-1:0] usb_addr,
	input wire logic [HRCS_CFG_W-1:0] usb_config,
	input wire logic transaction_translator_flush,
	input wire logic suspended,
	input wire logic downstream_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Four samples cover the synchroniser and the output register.
	sequence held;
		(attach && usb_bus_reset) [*4];
	endsequence
	a_attach_op: assert property (attach |-> operational)
		else $error("attach early");
	a_attach_stays: assert property (attach |=> attach)
		else $error("attach dropped");
	a_read_first: assert property (eeprom_start |-> !attach)
		else $error("attach before read");
	a_no_fwd: assert property (!downstream_reset)
		else $error("reset forwarded");
	a_rst_addr: assert property (held |=> usb_addr == 7'h00)
		else $error("address kept");
	a_rst_cfg: assert property (held |=> usb_config == 8'h00)
		else $error("config kept");
	a_rst_flush: assert property (held |=> transaction_translator_flush)
		else $error("no flush");
	a_rst_wake: assert property (held |=> !suspended)
		else $error("still suspended");
	a_flush_live: assert property (transaction_translator_flush |-> attach)
		else $error("flush before attach");
endmodule

//--- test/test_hrcs_sequencer.sv
// Testbench of the reset sequencer.
`timescale 1ns/1ns
module test_hrcs_sequencer;
	import hrcs_pkg::*;
	localparam int REC = 8;
	localparam int RD = 6;
	localparam int SMB_AT = 60;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] cfg_sel = 2'h0;
	logic suspend_req = 1'b0;
	logic [3:0] charge = 4'h0;
	hrcs_load_s smb_load = '0;
	hrcs_core_s core_req = '0;
	logic eeprom_done, usb_bus_reset, operational, eeprom_start, attach;
	logic transaction_translator_flush, suspended, downstream_reset;
	logic [3:0] eeprom_charge, port_power_enable, charge_port_enable;
	logic [6:0] usb_addr;
	logic [7:0] usb_config;
	int fail_count = 0;
	int cmp_count = 0;
	hrcs_sequencer #(.RECOVER_CYC(REC)) DUT (.mclk, .rst_n, .cfg_sel,
		.eeprom_done, .smb_load, .eeprom_charge, .usb_bus_reset,
		.suspend_req, .core_req, .operational, .eeprom_start, .attach,
		.usb_addr, .usb_config, .port_power_enable, .charge_port_enable,
		.transaction_translator_flush, .suspended, .downstream_reset);
	hrcs_partner #(.RD(RD)) u_far (.mclk, .rst_n, .eeprom_start, .attach,
		.charge,
		.eeprom_done, .eeprom_charge, .usb_bus_reset);
	initial begin
		forever #2 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic go(input logic [1:0] sel, input bit fl);
		int n;
		int due;
		logic [7:0] strap;
		due = REC + 1;
		if (sel == HRCS_SEL_EEPROM) due = REC + 3 + RD;
		if (sel == HRCS_SEL_SMBUS) due = SMB_AT + 1;
		strap = 8'(sel == HRCS_SEL_STRAP);
		rst_n = 1'b0;
		cfg_sel = sel;
		tick(2);
		chk(8'(attach), 8'h00);
		rst_n = 1'b1;
		for (n = 0; (fl ? transaction_translator_flush : attach) !== 1'b1;
			n++) begin
			if (n > 300) begin
				fail_count++;
				stop_test();
			end
			// A load strobe during recovery must be ignored.
			if (n == 2) smb_load = '{1'b1, 4'h6};
			if (n == 3) smb_load = '0;
			if (n == REC - 1) chk(8'(operational), 8'h00);
			if (n == REC) chk(8'(operational), 8'h01);
			if (n == REC + 2) chk(8'(attach), strap);
			if (n == SMB_AT) begin
				chk(8'(attach), 8'h00);
				smb_load = '{1'b1, 4'h9};
			end
			tick(1);
		end
		smb_load = '0;
		if (!fl) chk(8'(n), 8'(due));
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_strap();
		core_req = '{1'b1, 7'h05, 1'b1, 8'h01, 4'hF};
		suspend_req = 1'b1;
		go(HRCS_SEL_STRAP, 1'b0);
		tick(6);
		chk(8'(usb_addr), 8'h05);
		chk(usb_config, 8'h01);
		chk(8'(port_power_enable), 8'h0F);
		chk(8'(suspended), 8'h01);
		go(HRCS_SEL_STRAP, 1'b1);
		tick(4);
		chk(8'(usb_addr), 8'h00);
		chk(usb_config, 8'h00);
		chk(8'(port_power_enable & ~charge_port_enable), 8'h00);
		chk(8'(suspended), 8'h00);
		chk(8'(downstream_reset), 8'h00);
		suspend_req = 1'b0;
	endtask
	task automatic t_eeprom();
		charge = 4'h5;
		go(HRCS_SEL_EEPROM, 1'b0);
		chk(8'(charge_port_enable), 8'h05);
		tick(24);
		chk(8'(transaction_translator_flush), 8'h01);
		chk(8'(port_power_enable), 8'h05);
	endtask
	task automatic t_smbus();
		go(HRCS_SEL_SMBUS, 1'b0);
		chk(8'(charge_port_enable), 8'h09);
	endtask
	task automatic t_sel3();
		go(2'h3, 1'b0);
		chk(8'(charge_port_enable), 8'h00);
	endtask
	initial begin
		t_strap();
		t_eeprom();
		t_smbus();
		t_sel3();
		stop_test();
	end
endmodule
bind hrcs_sequencer hrcs_sequencer_sva u_sva (.mclk, .rst_n, .usb_bus_reset,
	.operational, .eeprom_start, .attach, .usb_addr, .usb_config,
	.transaction_translator_flush, .suspended, .downstream_reset);
